// [adc_spi_pkg.sv]
package adc_spi_pkg;
  // ----------------------------------------
  // serial frame layout
  // ----------------------------------------
  localparam int INSTR_W = 16;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 13;
  localparam int INSTR_RD_BIT = 15;
  localparam logic [4:0] LAST_INSTR_BIT = 5'h0F;
  localparam logic [4:0] FIRST_DATA_BIT = 5'h10;
  localparam logic [4:0] LAST_DATA_BIT = 5'h17;
  localparam logic [4:0] FRAME_END = 5'h18;
  localparam int NUM_CH = 4;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_PORT_CFG = 13'h0000;
  localparam logic [ADDR_W-1:0] ADDR_CHIP_IDENTITY = 13'h0001;
  localparam logic [ADDR_W-1:0] ADDR_SPEED_GRADE = 13'h0002;
  localparam logic [ADDR_W-1:0] ADDR_CH_SEL = 13'h0005;
  localparam logic [ADDR_W-1:0] ADDR_PWR_MODE = 13'h0008;
  localparam logic [ADDR_W-1:0] ADDR_CLK_CTRL = 13'h0009;
  localparam logic [ADDR_W-1:0] ADDR_TRANSFER = 13'h00FF;
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int PCFG_LSB_HI = 6;
  localparam int PCFG_LSB_LO = 1;
  localparam int PCFG_SRST_HI = 5;
  localparam int PCFG_SRST_LO = 2;
  localparam logic [7:0] PCFG_FIXED = 8'h18;
  localparam logic [3:0] CH_SEL_RST = 4'hF;
  localparam int PWR_PIN_FN_BIT = 5;
  localparam logic [7:0] PWR_MASK = 8'h33;
  localparam logic [7:0] PWR_RST = 8'h00;
  localparam logic [7:0] CLK_MASK = 8'h01;
  localparam logic [7:0] CLK_RST = 8'h00;
  localparam int XFER_GO_BIT = 0;
  localparam logic [7:0] XFER_RST = 8'h00;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {PM_NORMAL, PM_POWER_DOWN, PM_STANDBY, PM_DIGITAL_RESET} power_mode_t;
  typedef enum logic {LK_INSTR, LK_DATA} link_phase_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } wr_req_t;
endpackage

// [adc_spi_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module adc_spi_regs
  import adc_spi_pkg::*;
#(
  parameter logic [7:0] CHIP_IDENTITY = 8'h5A,    // arbitrary value
  parameter logic [7:0] SPEED_GRADE = 8'h30 // arbitrary value
)
(
  // core clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // three-wire serial port
  input wire logic i_sclk,
  input wire logic i_csb,
  input wire logic i_sdio,
  output logic o_sdio,
  output logic o_sdio_oe,
  // power-down pin
  input wire logic i_power_down_pin,
  // device controls
  output adc_spi_pkg::power_mode_t [adc_spi_pkg::NUM_CH-1:0] o_ch_power_state,
  output logic o_duty_stabilizer_en,
  output logic o_transfer_start
);
  import adc_spi_pkg::*;

  // ----------------------------------------
  // core register state
  // ----------------------------------------
  logic lsb_first_ff;
  logic [3:0] ch_sel_ff;
  logic [NUM_CH-1:0][7:0] pwr_reg_ff;
  logic [7:0] clk_reg_ff;
  logic [7:0] xfer_ff;
  power_mode_t [NUM_CH-1:0] ch_state_ff;
  logic pin_s1_ff;
  logic pin_s2_ff;

  // ----------------------------------------
  // link side (serial clock domain)
  // ----------------------------------------
  // the frame is bounded by chip select, so it clears the link state except the write request and the lsb-first sync
  logic [4:0] bit_cnt_ff;
  logic [INSTR_W-1:0] shift_ff;
  link_phase_t phase_ff;
  logic is_read_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [7:0] rd_byte_ff;
  wr_req_t wr_req_ff;
  logic wr_tgl_ff;
  logic out_ff;
  logic oe_ff;
  logic lsb_l1_ff;
  logic lsb_l2_ff;

  wire [INSTR_W-1:0] raw_instr = {shift_ff[INSTR_W-2:0], i_sdio};
  wire [INSTR_W-1:0] rev_instr = {<<{raw_instr}};
  wire [INSTR_W-1:0] link_instr = lsb_l2_ff ? rev_instr : raw_instr;
  wire [ADDR_W-1:0] link_addr = link_instr[ADDR_W-1:0];
  wire [7:0] raw_data = {shift_ff[6:0], i_sdio};
  wire [7:0] rev_data = {<<{raw_data}};
  wire [7:0] link_data = lsb_l2_ff ? rev_data : raw_data;
  wire instr_done = (bit_cnt_ff == LAST_INSTR_BIT);
  wire data_done = (bit_cnt_ff == LAST_DATA_BIT);
  wire [2:0] out_idx = bit_cnt_ff[2:0];
  wire [2:0] out_bit = lsb_l2_ff ? out_idx : 3'h7 - out_idx;
  wire in_read_data = is_read_ff && (phase_ff == LK_DATA) && (bit_cnt_ff < FRAME_END);

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  // registers are static during a frame, so the link samples them directly
  wire [1:0] rd_ch = ch_sel_ff[0] ? 2'h0 : ch_sel_ff[1] ? 2'h1 : ch_sel_ff[2] ? 2'h2 : 2'h3;
  wire [7:0] pcfg_value = PCFG_FIXED | {1'b0, lsb_first_ff, 4'h0, lsb_first_ff, 1'b0};
  wire [7:0] rd_value =
    (link_addr == ADDR_PORT_CFG) ? pcfg_value :
    (link_addr == ADDR_CHIP_IDENTITY) ? CHIP_IDENTITY :
    (link_addr == ADDR_SPEED_GRADE) ? SPEED_GRADE :
    (link_addr == ADDR_CH_SEL) ? {4'h0, ch_sel_ff} :
    (link_addr == ADDR_PWR_MODE) ? pwr_reg_ff[rd_ch] :
    (link_addr == ADDR_CLK_CTRL) ? clk_reg_ff :
    (link_addr == ADDR_TRANSFER) ? xfer_ff : 8'h00;

  // lsb-first is quasi-static; no reset so it survives between frames
  always_ff @(posedge i_sclk)
  begin
    lsb_l1_ff <= lsb_first_ff;
    lsb_l2_ff <= lsb_l1_ff;
  end

  always_ff @(posedge i_sclk or posedge i_csb)
  begin
    if (i_csb)
    begin
      bit_cnt_ff <= 5'h00;
      shift_ff <= 16'h0000;
      phase_ff <= LK_INSTR;
      is_read_ff <= 1'b0;
      addr_ff <= 13'h0000;
      rd_byte_ff <= 8'h00;
    end
    else
    begin
      shift_ff <= raw_instr;
      if (bit_cnt_ff < FRAME_END)
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
      if (instr_done)
      begin
        phase_ff <= LK_DATA;
        is_read_ff <= link_instr[INSTR_RD_BIT];
        addr_ff <= link_addr;
        rd_byte_ff <= rd_value;
      end
    end
  end

  // write request is held until the next frame, so the core reads it stable
  always_ff @(posedge i_sclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_req_ff <= '0;
      wr_tgl_ff <= 1'b0;
    end
    else if (!i_csb && data_done && !is_read_ff && phase_ff == LK_DATA)
    begin
      wr_req_ff <= '{addr: addr_ff, data: link_data};
      wr_tgl_ff <= ~wr_tgl_ff;
    end
  end

  // read data launched on the falling edge, sampled by host on the rising edge
  always_ff @(negedge i_sclk or posedge i_csb)
  begin
    if (i_csb)
    begin
      out_ff <= 1'b0;
      oe_ff <= 1'b0;
    end
    else
    begin
      out_ff <= in_read_data ? rd_byte_ff[out_bit] : 1'b0;
      oe_ff <= in_read_data;
    end
  end

  assign o_sdio = out_ff;
  assign o_sdio_oe = oe_ff;

  // ----------------------------------------
  // crossing into the core domain
  // ----------------------------------------
  logic tgl_s1_ff;
  logic tgl_s2_ff;
  logic tgl_s3_ff;

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
      tgl_s3_ff <= 1'b0;
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
    end
    else
    begin
      tgl_s1_ff <= wr_tgl_ff;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_s3_ff <= tgl_s2_ff;
      pin_s1_ff <= i_power_down_pin;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  wire wr_evt = tgl_s2_ff ^ tgl_s3_ff;
  wire [7:0] wr_data = wr_req_ff.data;
  wire wr_pcfg = wr_evt && (wr_req_ff.addr == ADDR_PORT_CFG);
  wire soft_rst = wr_pcfg && (wr_data[PCFG_SRST_HI] || wr_data[PCFG_SRST_LO]);
  wire wr_ch_sel = wr_evt && (wr_req_ff.addr == ADDR_CH_SEL);
  wire wr_pwr = wr_evt && (wr_req_ff.addr == ADDR_PWR_MODE);
  wire wr_clk = wr_evt && (wr_req_ff.addr == ADDR_CLK_CTRL);
  wire wr_xfer = wr_evt && (wr_req_ff.addr == ADDR_TRANSFER);
  wire nxt_lsb_first = wr_data[PCFG_LSB_HI] || wr_data[PCFG_LSB_LO];

  // ----------------------------------------
  // global registers
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || soft_rst)
    begin
      lsb_first_ff <= 1'b0;
      ch_sel_ff <= CH_SEL_RST;
      clk_reg_ff <= CLK_RST;
      xfer_ff <= XFER_RST;
    end
    else
    begin
      if (wr_pcfg)
        lsb_first_ff <= nxt_lsb_first;
      if (wr_ch_sel)
        ch_sel_ff <= wr_data[3:0];
      if (wr_clk)
        clk_reg_ff <= wr_data & CLK_MASK;
      // override runs in one cycle, so the bit clears on the next edge
      xfer_ff[XFER_GO_BIT] <= wr_xfer && wr_data[XFER_GO_BIT];
    end
  end

  assign o_duty_stabilizer_en = clk_reg_ff[0];
  assign o_transfer_start = xfer_ff[XFER_GO_BIT];

  // ----------------------------------------
  // channel-local registers
  // ----------------------------------------
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    wire [1:0] mode_bits = pwr_reg_ff[g][1:0];
    wire pin_fn_standby = pwr_reg_ff[g][PWR_PIN_FN_BIT];
    wire power_mode_t nxt_state = pin_s2_ff ? (pin_fn_standby ? PM_STANDBY : PM_POWER_DOWN)
                                            : power_mode_t'(mode_bits);

    always_ff @(posedge i_clk)
    begin
      if (!i_resetn || soft_rst)
      begin
        pwr_reg_ff[g] <= PWR_RST;
        ch_state_ff[g] <= PM_NORMAL;
      end
      else
      begin
        if (wr_pwr && ch_sel_ff[g])
          pwr_reg_ff[g] <= wr_data & PWR_MASK;
        ch_state_ff[g] <= nxt_state;
      end
    end
  end

  assign o_ch_power_state = ch_state_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  soft_reset_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    soft_rst |=> (ch_sel_ff == CH_SEL_RST) && !lsb_first_ff && (pwr_reg_ff[0] == PWR_RST) &&
      (pwr_reg_ff[3] == PWR_RST) && (clk_reg_ff == CLK_RST) && !pcfg_value[PCFG_SRST_HI])
    else $error("soft reset did not restore defaults");
  broadcast_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (wr_pwr && ch_sel_ff == 4'hF) |=> (pwr_reg_ff[0] == pwr_reg_ff[3]) &&
      (pwr_reg_ff[1] == (wr_data & PWR_MASK)) && (pwr_reg_ff[2] == pwr_reg_ff[1]))
    else $error("broadcast write missed a channel");
  unselected_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (wr_pwr && !ch_sel_ff[2]) |=> $stable(pwr_reg_ff[2]))
    else $error("unselected channel was written");
  read_chan0_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (ch_sel_ff == 4'hF && link_addr == ADDR_PWR_MODE) |-> rd_value == pwr_reg_ff[0])
    else $error("all-select read did not return channel 0");
  global_clock_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    wr_clk |=> clk_reg_ff == ($past(wr_data) & CLK_MASK))
    else $error("global write depended on channel select");
  port_cfg_fixed_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (pcfg_value & 8'h99) == PCFG_FIXED && pcfg_value[PCFG_LSB_HI] == pcfg_value[PCFG_LSB_LO])
    else $error("port configuration fixed bits wrong");
  transfer_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (wr_xfer && wr_data[XFER_GO_BIT]) |=> o_transfer_start ##1 !o_transfer_start)
    else $error("transfer bit did not self clear");
  pin_function_a: assert property (@(posedge i_clk) disable iff (!i_resetn || soft_rst)
    (pin_s2_ff && pwr_reg_ff[3][PWR_PIN_FN_BIT]) |=> ch_state_ff[3] == PM_STANDBY)
    else $error("power-down pin did not give standby");
  mode_select_a: assert property (@(posedge i_clk) disable iff (!i_resetn || soft_rst)
    (!pin_s2_ff && !wr_pwr) |=> ch_state_ff[0] == power_mode_t'($past(pwr_reg_ff[0][1:0])))
    else $error("power mode not applied");
  // checked at the next frame's first edge; chip select rises in between
  frame_write_a: assert property (@(posedge i_sclk) disable iff (!i_resetn)
    (!i_csb && data_done && !is_read_ff && phase_ff == LK_DATA) |=>
      wr_tgl_ff != $past(wr_tgl_ff))
    else $error("24-bit write frame not delivered");
endmodule
`default_nettype wire

// [spi_host.sv]
`timescale 1ns/10ps
`default_nettype none
module spi_host
(
  // three-wire serial lines
  output logic o_sclk,
  output logic o_csb,
  output logic o_sdio,
  input wire logic i_sdio
);
  // serial clock stands still low between frames
  initial
  begin
    o_sclk = 1'b0;
    o_csb = 1'b1;
    o_sdio = 1'b0;
  end
  // ----------------------------------------
  // one frame: 16-bit instruction, one data byte
  // ----------------------------------------
  task automatic xfer(input logic rd, input logic lsb, input logic [12:0] addr,
                      input logic [7:0] wdat, output logic [7:0] rdat);
    logic [15:0] ins;
    logic [7:0] d;
    ins = {rd, 2'b00, addr};
    d = wdat;
    if (lsb)
    begin
      ins = {<<{ins}};
      d = {<<{d}};
    end
    o_csb = 1'b0;
    for (int i = 0; i < 24; i++)
    begin
      // released line toggles so a stale level cannot pass for data
      o_sdio = (i < 16) ? ins[15-i] : (rd ? ~o_sdio : d[23-i]);
      #7.5 o_sclk = 1'b1;
      if (i >= 16) rdat[23-i] = i_sdio;
      #7.5 o_sclk = 1'b0;
    end
    o_csb = 1'b1;
    if (lsb) rdat = {<<{rdat}};
    // gap covers the core-side crossing of a write
    #200;
  endtask
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  import adc_spi_pkg::*;
  localparam logic [7:0] ID = 8'hA7; // arbitrary value
  localparam logic [7:0] SG = 8'h3C; // arbitrary value
  logic i_clk, i_resetn, pin, sclk, csb, hsdio, dsdio, oe, dse, xs;
  wire sdio;
  power_mode_t [NUM_CH-1:0] pst;
  int n_fail, check_count, pulses, seed;
  logic [7:0] rd;
  logic [7:0] pm [NUM_CH];
  assign sdio = oe ? dsdio : hsdio;
  adc_spi_regs #(.CHIP_IDENTITY(ID), .SPEED_GRADE(SG)) i_dut (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_sclk(sclk), .i_csb(csb), .i_sdio(sdio), .o_sdio(dsdio), .o_sdio_oe(oe),
    .i_power_down_pin(pin), .o_ch_power_state(pst), .o_duty_stabilizer_en(dse),
    .o_transfer_start(xs));
  spi_host i_host (.o_sclk(sclk), .o_csb(csb), .o_sdio(hsdio), .i_sdio(sdio));
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  always @(negedge i_clk) if (xs === 1'b1) pulses++;
  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] got);
    check_count++;
    if (got !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic l = 1'b0);
    i_host.xfer(1'b0, l, a, d, rd);
  endtask
  task automatic rdc(input string nm, input logic [12:0] a, input logic [7:0] e,
                     input logic l = 1'b0);
    i_host.xfer(1'b1, l, a, 8'h00, rd);
    chk(nm, e, rd);
  endtask
  function automatic logic [1:0] pexp(input logic [7:0] r, input logic p);
    return p ? (r[5] ? 2'd2 : 2'd1) : r[1:0];
  endfunction
  task automatic chk_pst(input logic p);
    for (int c = 0; c < NUM_CH; c++)
      chk("power state", {6'h00, pexp(pm[c], p)}, {6'h00, pst[c]});
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_fail++;
    end_sim;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    seed = 32'h58A4E24E;
    i_resetn = 1'b0;
    pin = 1'b0;
    repeat (10) @(negedge i_clk);
    i_resetn = 1'b1;
    repeat (2) @(negedge i_clk);
    rdc("port config", 13'h0000, 8'h18);
    rdc("chip identity", 13'h0001, ID);
    rdc("speed grade", 13'h0002, SG);
    rdc("channel select", 13'h0005, 8'h0F);
    rdc("power mode", 13'h0008, 8'h00);
    rdc("clock control", 13'h0009, 8'h00);
    rdc("transfer", 13'h00FF, 8'h00);
    rdc("unmapped", 13'h0003, 8'h00);
    $display("test reset values done");
    for (int c = 0; c < NUM_CH; c++)
    begin
      pm[c] = (c == 3) ? 8'h33 : (8'($random(seed)) & ((c == 0) ? 8'h13 : 8'h33));
      wr(13'h0005, 8'h01 << c);
      wr(13'h0008, pm[c]);
    end
    chk_pst(1'b0);
    for (int c = 0; c < NUM_CH; c++)
    begin
      wr(13'h0005, 8'h01 << c);
      rdc("local power mode", 13'h0008, pm[c]);
    end
    wr(13'h0005, 8'h0F);
    rdc("all selected read", 13'h0008, pm[0]);
    @(negedge i_clk) pin = 1'b1;
    repeat (5) @(negedge i_clk);
    chk_pst(1'b1);
    @(negedge i_clk) pin = 1'b0;
    wr(13'h0008, 8'h02);
    for (int c = 0; c < NUM_CH; c++) pm[c] = 8'h02;
    chk_pst(1'b0);
    $display("test channel registers done");
    wr(13'h0005, 8'h02);
    wr(13'h0009, 8'h01);
    chk("duty stabilizer", 8'h01, {7'h00, dse});
    wr(13'h0005, 8'h04);
    rdc("clock control", 13'h0009, 8'h01);
    pulses = 0;
    wr(13'h00FF, 8'h01);
    chk("transfer pulses", 8'h01, pulses[7:0]);
    rdc("transfer", 13'h00FF, 8'h00);
    $display("test global registers done");
    wr(13'h0000, 8'h42);
    // first frame after a mode change only lets the sync settle
    i_host.xfer(1'b1, 1'b1, 13'h0001, 8'h00, rd);
    rdc("port config lsb", 13'h0000, 8'h5A, 1'b1);
    wr(13'h0000, 8'h24, 1'b1);
    i_host.xfer(1'b1, 1'b0, 13'h0001, 8'h00, rd);
    rdc("port config", 13'h0000, 8'h18);
    rdc("channel select", 13'h0005, 8'h0F);
    rdc("clock control", 13'h0009, 8'h00);
    rdc("power mode", 13'h0008, 8'h00);
    chk("duty stabilizer", 8'h00, {7'h00, dse});
    $display("test bit order and soft reset done");
    end_sim;
  end
endmodule
`default_nettype wire
